/* bench/ladder_model.sv */
module ladder_model (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// contact commands from the test sequence
	input  wire logic [15:0] ev_set,
	// event contacts toward the sequencer
	output logic      [15:0] event_in
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [15:0] contact_reg;
	logic [15:0] contact_next;

	// contacts settle one scan after the command, like a coil driving a contact
	always_comb begin
		contact_next = ev_set;
	end

	// contacts are open after power-up so no step sees a stray event
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			contact_reg <= 16'h0000;
		end else begin
			contact_reg <= contact_next;
		end
	end

	assign event_in = contact_reg;
endmodule

/* bench/tb.sv */
module tb import seq_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;

	logic        pclk    = 1'b0;
	logic        presetn = 1'b0;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [11:0] paddr   = 12'h000;
	logic [31:0] pwdata  = 32'h0;
	logic [15:0] ev_set  = 16'h0000;
	logic        pready;
	logic [31:0] prdata;
	logic        pslverr;
	logic [15:0] event_in;
	logic [15:0] discrete;
	logic [15:0] word_out;
	logic        drum_done;
	logic        irq;
	logic [31:0] r_data;
	logic        r_err;
	int          n_mismatch = 0;
	int          checks     = 0;

	// 50 MHz clock
	always #10 pclk = ~pclk;

	// short timer tick keeps each timer unit at four clocks
	masked_event_step_sequencer #(.TICK_CYCLES(4)) dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .event_in(event_in),
		.masked_drum_discrete(discrete), .masked_drum_word(word_out),
		.drum_done(drum_done), .irq(irq));

	ladder_model partner (.pclk(pclk), .presetn(presetn), .ev_set(ev_set), .event_in(event_in));

	task automatic close_out;
		if (n_mismatch == 0 && checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one apb transfer; request held until pready is seen at an edge
	task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r_data = prdata;
		r_err  = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		xfer(a, 1'b1, d);
		cmp({31'h0, r_err}, 32'h0);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		xfer(a, 1'b0, 32'h0);
		cmp(r_data, exp);
	endtask

	// hang guard, far beyond the few hundred cycles the sequence needs
	initial begin
		repeat (5000) @(posedge pclk);
		n_mismatch++;
		close_out;
	end

	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		rd(TIMEBASE_OFS, 32'h1);
		rd(PSTEP_OFS, 32'h1);
		rd(CUR_STEP_OFS, 32'h1);
		rd(12'h0d0, 32'h0);
		rd(12'h07c, 32'h0);
		xfer(12'h02c, 1'b0, 32'h0);
		cmp({31'h0, r_err}, 32'h1);
		// step 1 timed, step 2 gated by contact 0
		wr(12'h080, 32'h2);
		wr(12'h084, 32'h1);
		wr(12'h0c4, 32'h1);
		wr(12'h040, 32'hffff);
		wr(12'h044, 32'h00ff);
		wr(12'h088, 32'h2710);
		rd(12'h088, 32'h0);
		wr(MASK_BASE_OFS, 32'h4);
		wr(12'h110, 32'h0f0f);
		wr(12'h114, 32'hffff);
		wr(INT_EN_OFS, 32'h1);
		wr(CTRL_OFS, 32'h8);
		repeat (3) @(posedge pclk);
		cmp({16'h0, discrete}, 32'h0f0f);
		cmp({16'h0, word_out}, 32'h0);
		wr(12'h110, 32'h00f0);
		repeat (3) @(posedge pclk);
		cmp({16'h0, discrete}, 32'h00f0);
		rd(OUTPUT_OFS, 32'h00f0);
		// start the timer: step 1 runs out, step 2 waits on its contact
		wr(CTRL_OFS, 32'h9);
		repeat (40) @(posedge pclk);
		rd(CUR_STEP_OFS, 32'h2);
		rd(COUNTS_OFS, 32'h0);
		rd(TIMER_OFS, 32'h0);
		cmp({16'h0, discrete}, 32'h00ff);
		cmp({31'h0, irq}, 32'h1);
		rd(INT_STAT_OFS, 32'h1);
		wr(INT_CLR_OFS, 32'h1);
		wr(INT_EN_OFS, 32'h0);
		repeat (3) @(posedge pclk);
		cmp({31'h0, irq}, 32'h0);
		// contact true but start off: nothing moves
		wr(CTRL_OFS, 32'h8);
		ev_set <= 16'h0001;
		repeat (40) @(posedge pclk);
		rd(CUR_STEP_OFS, 32'h2);
		wr(CTRL_OFS, 32'h9);
		repeat (20) @(posedge pclk);
		cmp({31'h0, drum_done}, 32'h1);
		cmp({31'h0, irq}, 32'h0);
		wr(INT_EN_OFS, 32'h2);
		repeat (3) @(posedge pclk);
		cmp({31'h0, irq}, 32'h1);
		ev_set <= 16'h0000;
		// drum reset, then jog with start off
		wr(CTRL_OFS, 32'hc);
		wr(CTRL_OFS, 32'h8);
		repeat (2) @(posedge pclk);
		cmp({31'h0, drum_done}, 32'h0);
		rd(CUR_STEP_OFS, 32'h1);
		rd(COUNTS_OFS, 32'h0);
		wr(CTRL_OFS, 32'ha);
		wr(CTRL_OFS, 32'h8);
		rd(CUR_STEP_OFS, 32'h2);
		rd(TIMER_OFS, 32'h0);
		wr(PSTEP_OFS, 32'h11);
		rd(PSTEP_OFS, 32'h1);
		wr(CTRL_OFS, 32'hc);
		wr(CTRL_OFS, 32'h8);
		rd(CUR_STEP_OFS, 32'h1);
		wr(PSTEP_OFS, 32'h2);
		rd(PSTEP_OFS, 32'h2);
		wr(CTRL_OFS, 32'hc);
		wr(CTRL_OFS, 32'h8);
		rd(CUR_STEP_OFS, 32'h2);
		wr(CUR_STEP_OFS, 32'h5);
		rd(CUR_STEP_OFS, 32'h2);
		// timer base of two units: the timer value reaches one inside the first count
		wr(TIMEBASE_OFS, 32'h2710);
		rd(TIMEBASE_OFS, 32'h1);
		wr(TIMEBASE_OFS, 32'h2);
		wr(PSTEP_OFS, 32'h1);
		wr(CTRL_OFS, 32'hc);
		wr(CTRL_OFS, 32'h9);
		repeat (3) @(posedge pclk);
		rd(TIMER_OFS, 32'h1);
		// let step 1 finish its two counts so step 2 is current again
		repeat (12) @(posedge pclk);
		// word variant moves the masked bits off the discrete points
		wr(CTRL_OFS, 32'h18);
		repeat (3) @(posedge pclk);
		cmp({16'h0, word_out}, 32'h00ff);
		cmp({16'h0, discrete}, 32'h0);
		close_out;
	end
endmodule

/* common/seq_pkg.sv */
package seq_pkg;

	// sequencer geometry
	localparam int unsigned STEPS      = 16;
	localparam int unsigned MASK_WORDS = 32;
	localparam int unsigned CNT_W      = 14;

	// documented ranges
	localparam logic [13:0] CPS_MAX      = 14'h270f;
	localparam logic [13:0] TIMEBASE_MAX = 14'h270f;
	localparam logic [4:0]  PSTEP_MIN    = 5'h01;
	localparam logic [4:0]  PSTEP_MAX    = 5'h10;

	// timer base unit: 0.01 s, expressed in ns, against the 20 ns clock
	localparam longint unsigned TB_UNIT_NS    = 64'd10000000;
	localparam longint unsigned CLK_PERIOD_NS = 64'd20;
	localparam int unsigned     TICK_CYCLES_DEF = int'(TB_UNIT_NS / CLK_PERIOD_NS);

	// register byte offsets
	localparam logic [11:0] CTRL_OFS       = 12'h000;
	localparam logic [11:0] TIMEBASE_OFS   = 12'h004;
	localparam logic [11:0] MASK_BASE_OFS  = 12'h008;
	localparam logic [11:0] OUTPUT_OFS     = 12'h00c;
	localparam logic [11:0] COUNTS_OFS     = 12'h010;
	localparam logic [11:0] TIMER_OFS      = 12'h014;
	localparam logic [11:0] PSTEP_OFS      = 12'h018;
	localparam logic [11:0] CUR_STEP_OFS   = 12'h01c;
	localparam logic [11:0] INT_STAT_OFS   = 12'h020;
	localparam logic [11:0] INT_EN_OFS     = 12'h024;
	localparam logic [11:0] INT_CLR_OFS    = 12'h028;
	localparam logic [5:0]  PATTERN_BLK    = 6'h01;   // 0x040 + 4*step
	localparam logic [5:0]  CPS_BLK        = 6'h02;   // 0x080 + 4*step
	localparam logic [5:0]  EVSEL_BLK      = 6'h03;   // 0x0c0 + 4*step
	localparam logic [4:0]  MASK_BLK       = 5'h02;   // 0x100 + 4*word

	// control register fields and the counts register done bit
	localparam int unsigned CTRL_START = 0;
	localparam int unsigned CTRL_JOG   = 1;
	localparam int unsigned CTRL_RESET = 2;
	localparam int unsigned CTRL_RUN   = 3;
	localparam int unsigned CTRL_WORD  = 4;
	localparam int unsigned DONE_BIT   = 31;

	// interrupt bits
	localparam int unsigned INT_STEP = 0;
	localparam int unsigned INT_DONE = 1;

	// reset values
	localparam logic [4:0]  CTRL_RST     = 5'h00;
	localparam logic [13:0] TIMEBASE_RST = 14'h0001;
	localparam logic [4:0]  PSTEP_RST    = 5'h01;

	typedef enum logic [1:0] {ST_PROG, ST_RUN, ST_DONE} seq_state_t;

endpackage

/* rtl/masked_event_step_sequencer.sv */
module masked_event_step_sequencer
	import seq_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
) (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// event contacts from the controlling logic
	input  wire logic [15:0] event_in,
	// drum outputs
	output logic [15:0]      masked_drum_discrete,
	output logic [15:0]      masked_drum_word,
	output logic             drum_done,
	output logic             irq
);

	// step tables and mask block
	logic [15:0]      pattern_mem [STEPS];
	logic [13:0]      cps_mem     [STEPS];
	logic [4:0]       evsel_mem   [STEPS];
	logic [15:0]      mask_mem    [MASK_WORDS];

	// software registers
	logic [4:0]       ctrl_reg, ctrl_next;
	logic [13:0]      timer_base_field_reg, timer_base_field_next;
	logic [4:0]       mask_base_reg, mask_base_next;
	logic [4:0]       preset_step_field_reg, preset_step_field_next;
	logic [1:0]       int_stat_reg, int_stat_next;
	logic [1:0]       int_en_reg, int_en_next;
	logic             pready_reg, pready_next;
	logic [31:0]      prdata_reg, prdata_next;
	logic             pslverr_reg, pslverr_next;

	// sequencer state
	seq_state_t       state_reg, state_next;
	logic [3:0]       cur_reg, cur_next;
	logic [13:0]      counts_reg, counts_next;
	logic [13:0]      timer_reg, timer_next;
	logic [31:0]      tick_reg, tick_next;
	logic             done_reg, done_next;
	logic             jog_prev_reg, run_prev_reg;
	logic [15:0]      points_reg, points_next;
	logic [15:0]      word_reg, word_next;
	logic             irq_reg, irq_next;

	// helpers
	logic             wr_en;
	logic             jog_rise, run_rise;
	logic [3:0]       last_used;
	logic             ev_true;
	logic [13:0]      tb_limit;
	logic [15:0]      final_val;
	logic [4:0]       mask_idx;
	logic             adv;
	logic [1:0]       ev_pulse;

	// every mapped word, tables included; anything else answers with pslverr
	function automatic logic addr_valid(input logic [11:0] a);
		logic ok;
		ok = 1'b0;
		if (a[1:0] == 2'b00) begin
			if (a <= INT_CLR_OFS)
				ok = 1'b1;
			if (a[11:6] == PATTERN_BLK || a[11:6] == CPS_BLK || a[11:6] == EVSEL_BLK)
				ok = 1'b1;
			if (a[11:7] == MASK_BLK)
				ok = 1'b1;
		end
		return ok;
	endfunction

	assign wr_en = psel & penable & pready_reg & pwrite & addr_valid(paddr);

	// register file next values; a refused preset step write leaves the old value
	always_comb begin
		ctrl_next              = ctrl_reg;
		timer_base_field_next  = timer_base_field_reg;
		mask_base_next         = mask_base_reg;
		preset_step_field_next = preset_step_field_reg;
		int_en_next            = int_en_reg;
		int_stat_next          = int_stat_reg;
		if (wr_en) begin
			case (paddr)
				CTRL_OFS:     ctrl_next = pwdata[4:0];
				TIMEBASE_OFS: if (pwdata[13:0] <= TIMEBASE_MAX)
					timer_base_field_next = pwdata[13:0];
				MASK_BASE_OFS: mask_base_next = pwdata[4:0];
				PSTEP_OFS: if (pwdata[4:0] >= PSTEP_MIN && pwdata[4:0] <= PSTEP_MAX &&
						pwdata[31:5] == 27'h0)
					preset_step_field_next = pwdata[4:0];
				INT_EN_OFS:   int_en_next = pwdata[1:0];
				INT_CLR_OFS:  int_stat_next = int_stat_reg & ~pwdata[1:0];
				default: ;
			endcase
		end
		// a new event in the clearing cycle survives the clear
		int_stat_next = int_stat_next | ev_pulse;
		irq_next      = |(int_stat_reg & int_en_reg);
	end

	// read data is captured in the setup cycle, so pready is high in the first access cycle
	always_comb begin
		pready_next  = psel & ~penable;
		pslverr_next = psel & ~penable & ~addr_valid(paddr);
		prdata_next  = 32'h0;
		if (psel && !penable && !pwrite && addr_valid(paddr)) begin
			case (paddr)
				CTRL_OFS:      prdata_next = {27'h0, ctrl_reg};
				TIMEBASE_OFS:  prdata_next = {18'h0, timer_base_field_reg};
				MASK_BASE_OFS: prdata_next = {27'h0, mask_base_reg};
				OUTPUT_OFS:    prdata_next = {16'h0, final_val};
				COUNTS_OFS:    prdata_next = {done_reg, 17'h0, counts_reg};
				TIMER_OFS:     prdata_next = {18'h0, timer_reg};
				PSTEP_OFS:     prdata_next = {27'h0, preset_step_field_reg};
				CUR_STEP_OFS:  prdata_next = {27'h0, 5'(cur_reg) + 5'h01};
				INT_STAT_OFS:  prdata_next = {30'h0, int_stat_reg};
				INT_EN_OFS:    prdata_next = {30'h0, int_en_reg};
				default: begin
					if (paddr[11:6] == PATTERN_BLK)
						prdata_next = {16'h0, pattern_mem[paddr[5:2]]};
					else if (paddr[11:6] == CPS_BLK)
						prdata_next = {18'h0, cps_mem[paddr[5:2]]};
					else if (paddr[11:6] == EVSEL_BLK)
						prdata_next = {27'h0, evsel_mem[paddr[5:2]]};
					else if (paddr[11:7] == MASK_BLK)
						prdata_next = {16'h0, mask_mem[paddr[6:2]]};
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg              <= CTRL_RST;
			timer_base_field_reg  <= TIMEBASE_RST;
			mask_base_reg         <= 5'h00;
			preset_step_field_reg <= PSTEP_RST;
			int_stat_reg          <= 2'h0;
			int_en_reg            <= 2'h0;
			irq_reg               <= 1'b0;
			pready_reg            <= 1'b0;
			prdata_reg            <= 32'h0;
			pslverr_reg           <= 1'b0;
		end else begin
			ctrl_reg              <= ctrl_next;
			timer_base_field_reg  <= timer_base_field_next;
			mask_base_reg         <= mask_base_next;
			preset_step_field_reg <= preset_step_field_next;
			int_stat_reg          <= int_stat_next;
			int_en_reg            <= int_en_next;
			irq_reg               <= irq_next;
			pready_reg            <= pready_next;
			prdata_reg            <= prdata_next;
			pslverr_reg           <= pslverr_next;
		end
	end

	// table storage; reset leaves every step blank and every mask at zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < STEPS; i++) begin
				pattern_mem[i] <= 16'h0;
				cps_mem[i]     <= 14'h0;
				evsel_mem[i]   <= 5'h0;
			end
			for (int j = 0; j < MASK_WORDS; j++)
				mask_mem[j] <= 16'h0;
		end else if (wr_en) begin
			if (paddr[11:6] == PATTERN_BLK)
				pattern_mem[paddr[5:2]] <= pwdata[15:0];
			if (paddr[11:6] == CPS_BLK && pwdata[13:0] <= CPS_MAX)
				cps_mem[paddr[5:2]] <= pwdata[13:0];
			if (paddr[11:6] == EVSEL_BLK && pwdata[4:0] <= PSTEP_MAX)
				evsel_mem[paddr[5:2]] <= pwdata[4:0];
			if (paddr[11:7] == MASK_BLK)
				mask_mem[paddr[6:2]] <= pwdata[15:0];
		end
	end

	// last step that has a count preset or an event assigned
	// trade-off: a blank step inside the used range still runs, as a one-cycle skip
	always_comb begin
		last_used = 4'h0;
		for (int i = 0; i < STEPS; i++)
			if (cps_mem[i] != 14'h0 || evsel_mem[i] != 5'h0)
				last_used = 4'(i);
	end

	assign jog_rise = ctrl_reg[CTRL_JOG] & ~jog_prev_reg;
	assign run_rise = ctrl_reg[CTRL_RUN] & ~run_prev_reg;
	// blank event reads as always true, making the step purely timed
	assign ev_true  = (evsel_mem[cur_reg] == 5'h0) ? 1'b1 :
		event_in[4'(evsel_mem[cur_reg] - 5'h01)];
	// a zero timer base would end a count on every tick, so it acts as one unit
	assign tb_limit = (timer_base_field_reg == 14'h0) ? 14'h0001 : timer_base_field_reg;
	// mask words follow the base in step order and wrap inside the mask block
	assign mask_idx  = mask_base_reg + 5'(cur_reg);
	assign final_val = pattern_mem[cur_reg] & mask_mem[mask_idx];

	// step sequencing
	always_comb begin
		state_next = state_reg;
		cur_next    = cur_reg;
		counts_next = counts_reg;
		timer_next  = timer_reg;
		tick_next   = tick_reg;
		done_next   = done_reg;
		adv         = 1'b0;
		ev_pulse    = 2'h0;
		if (!ctrl_reg[CTRL_RUN]) begin
			state_next = ST_PROG;
		end else if (ctrl_reg[CTRL_RESET] || run_rise) begin
			// held at the preset step for as long as reset stays on
			state_next  = ST_RUN;
			cur_next    = 4'(preset_step_field_reg - 5'h01);
			counts_next = 14'h0;
			timer_next  = 14'h0;
			tick_next   = 32'h0;
			done_next   = 1'b0;
		end else if (state_reg == ST_RUN) begin
			if (jog_rise) begin
				adv = 1'b1;
			end else if (ctrl_reg[CTRL_START] && ev_true) begin
				if (cps_mem[cur_reg] == 14'h0) begin
					adv = 1'b1;
				end else if (tick_reg == TICK_CYCLES - 1) begin
					tick_next = 32'h0;
					if (timer_reg + 14'h0001 >= tb_limit) begin
						timer_next  = 14'h0;
						counts_next = counts_reg + 14'h0001;
						if (counts_reg + 14'h0001 == cps_mem[cur_reg])
							adv = 1'b1;
					end else begin
						timer_next = timer_reg + 14'h0001;
					end
				end else begin
					tick_next = tick_reg + 32'h1;
				end
			end
			if (adv) begin
				counts_next = 14'h0;
				timer_next  = 14'h0;
				tick_next   = 32'h0;
				if (cur_reg >= last_used) begin
					state_next          = ST_DONE;
					done_next           = 1'b1;
					ev_pulse[INT_DONE] = 1'b1;
				end else begin
					cur_next           = cur_reg + 4'h1;
					ev_pulse[INT_STEP] = 1'b1;
				end
			end
		end
	end

	// outputs are one cycle behind the tables, so a mask write shows on the next edge
	always_comb begin
		word_next   = ctrl_reg[CTRL_WORD] ? final_val : 16'h0;
		points_next = ctrl_reg[CTRL_WORD] ? 16'h0 : final_val;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg    <= ST_PROG;
			cur_reg      <= 4'h0;
			counts_reg   <= 14'h0;
			timer_reg    <= 14'h0;
			tick_reg     <= 32'h0;
			done_reg     <= 1'b0;
			jog_prev_reg <= 1'b0;
			run_prev_reg <= 1'b0;
			points_reg   <= 16'h0;
			word_reg     <= 16'h0;
		end else begin
			state_reg    <= state_next;
			cur_reg      <= cur_next;
			counts_reg   <= counts_next;
			timer_reg    <= timer_next;
			tick_reg     <= tick_next;
			done_reg     <= done_next;
			jog_prev_reg <= ctrl_reg[CTRL_JOG];
			run_prev_reg <= ctrl_reg[CTRL_RUN];
			points_reg   <= points_next;
			word_reg     <= word_next;
		end
	end

	assign pready               = pready_reg;
	assign prdata               = prdata_reg;
	assign pslverr              = pslverr_reg;
	assign masked_drum_discrete = points_reg;
	assign masked_drum_word     = word_reg;
	assign drum_done            = done_reg;
	assign irq                  = irq_reg;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_reset_seen;
		ctrl_reg[CTRL_RUN] && ctrl_reg[CTRL_RESET];
	endsequence

	sequence s_quiet;
		ctrl_reg[CTRL_RUN] && !ctrl_reg[CTRL_RESET] && !run_rise && !jog_rise;
	endsequence

	// a jog edge that meets a drum reset loses to it, so that cycle is left out
	sequence s_jog_alone;
		ctrl_reg[CTRL_RUN] && !ctrl_reg[CTRL_RESET] && !run_rise && jog_rise;
	endsequence

	a_output_masked: assert property (
		ctrl_reg[CTRL_WORD] |=> masked_drum_word == $past(final_val))
		else $error("word output differs from pattern and mask");
	a_word_mode: assert property (
		ctrl_reg[CTRL_WORD] |=> masked_drum_discrete == 16'h0)
		else $error("points driven in word mode");
	a_reset_load: assert property (
		s_reset_seen |=> cur_reg == 4'($past(preset_step_field_reg) - 5'h01) && !drum_done)
		else $error("reset did not load preset step");
	a_jog_step: assert property (
		s_jog_alone ##0 (state_reg == ST_RUN) && cur_reg < last_used
		|=> cur_reg == $past(cur_reg) + 4'h1)
		else $error("jog edge did not advance one step");
	a_start_gate: assert property (
		s_quiet ##0 !ctrl_reg[CTRL_START] |=> $stable(tick_reg) && $stable(counts_reg))
		else $error("timer ran without start");
	a_event_gate: assert property (
		s_quiet ##0 !ev_true |=> $stable(timer_reg) && $stable(cur_reg))
		else $error("timer ran with event false");
	a_done_halt: assert property (
		s_quiet ##0 (state_reg == ST_DONE) |=> $stable(cur_reg) && drum_done)
		else $error("sequencer moved after completion");
	a_step_clear: assert property (
		$changed(cur_reg) |-> counts_reg == 14'h0 && timer_reg == 14'h0)
		else $error("counters not cleared on step change");
	a_done_set: assert property (
		s_quiet ##0 (state_reg == ST_RUN) && adv && cur_reg >= last_used
		|=> drum_done ##1 drum_done)
		else $error("completion bit missing after last step");
	a_pstep_range: assert property (
		preset_step_field_reg >= PSTEP_MIN && preset_step_field_reg <= PSTEP_MAX)
		else $error("preset step left its legal range");

endmodule
